// ==== verilog/alfd_defs.svh ====
/*
  Offsets, bit positions, reset values and timing figures of the amplifier load fault diagnostics block.
  Assumes a 25 MHz core clock and a word-aligned 32-bit register bus.
*/
`ifndef ALFD_DEFS_SVH
`define ALFD_DEFS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define ALFD_CLK_KHZ 25000
`define ALFD_SHORT_STABLE_MS 90
`define ALFD_OLP_SETTLE_MS 500
`define ALFD_OLP_WINDOW_MS 1000
`define ALFD_OLP_QUAL_MS 300
`define ALFD_AMP_TH25_MFS 67
`define ALFD_AMP_TH15_MFS 40
`define ALFD_LP_SHIFT 2

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ALFD_ADR_DETECTOR_START 8'h00
`define ALFD_ADR_GAIN_RAMP 8'h04
`define ALFD_ADR_LOAD_THR 8'h08
`define ALFD_ADR_LOAD_TEST_CTRL 8'h0C
`define ALFD_ADR_FAULT_ROUTE 8'h10
`define ALFD_ADR_MODE_CMD 8'h14
`define ALFD_ADR_LOAD_RESULT 8'h18
`define ALFD_ADR_PLAY_STATUS 8'h1C
`define ALFD_ADR_MUTE_STATUS 8'h20

// ----------------------------------------
// field positions
// ----------------------------------------
`define ALFD_OLP_START_BIT 0
`define ALFD_GAIN_BIT 4
`define ALFD_THR_SHORT_BIT 7
`define ALFD_THR_OPEN_BIT 6
`define ALFD_LT_START_BIT 0
`define ALFD_CMD_PWR_BIT 0
`define ALFD_CMD_PLAY_BIT 1
`define ALFD_RES_VCC_BIT 3
`define ALFD_RES_GND_BIT 2
`define ALFD_RES_OPEN_BIT 1
`define ALFD_RES_SHORT_BIT 0
`define ALFD_PS_DONE_BIT 2
`define ALFD_PS_VALID_BIT 1
`define ALFD_PS_OPEN_BIT 0
`define ALFD_MS_SAM_BIT 4
`define ALFD_ROUTE_W 5

// ----------------------------------------
// reset values
// ----------------------------------------
`define ALFD_RST_ROUTE 5'h00
`define ALFD_RST_RESULT 4'h0
`define ALFD_RST_PLAY 3'h0

`endif

// ==== verilog/alfd_pkg.sv ====
/*
  Types shared by the amplifier load fault diagnostics block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package alfd_pkg;
    typedef enum logic [1:0] {
        PR_IDLE = 2'b00,
        PR_SHORT_DIAG = 2'b01,
        PR_LOAD_TEST = 2'b11
    } alfd_prot_t;

    typedef enum logic [1:0] {
        OL_IDLE = 2'b00,
        OL_SETTLE = 2'b01,
        OL_EVAL = 2'b11
    } alfd_olp_t;
endpackage : alfd_pkg

// ==== verilog/alfd_load_diag.sv ====
/*
  Diagnostic sequencer of a single-channel amplifier: warning latches, fault pin, DC load test,
  short-to-supply/ground filter and open-load-in-play test, reached over classic Wishbone.
  Assumes the main state machine, analog front ends and comparators sit outside; their
  same-clock inputs need no synchroniser, pins and comparator levels pass two flip-flops.
*/
// Notes on behaviour
// R1 - warnings latch until next bus read
// R2 - selected faults pull fault pin low
// R3 - host reads status before collecting results
// R4 - test needs mute, start rise, power, no pin-mute
// R5 - test end clears start, posts result
// R6 - start outside mute waits for mute
// R7 - idle combined commands: power, test, play
// R8 - host keeps in-phase modulation during test
// R9 - short trip enters protected short diagnosis
// R10 - no short: test only if start set
// R11 - threshold bits select limits, result reported
// R12 - short diagnosis needs 90 ms stability
// R13 - stable short sets flag, stays there
// R14 - stable no-fault ends short diagnosis
// R15 - single-shot play test qualifies signal
// R16 - averaged impedance above threshold means open
// R17 - play test uses band up to 2 kHz
// R18 - amplitude gate 67 or 40 mFs
// R19 - valid after 300 ms within 1 s
// R20 - impedance threshold from select and gain bits
// R21 - start bit, 500 ms settle, flags, clear
// R22 - leaving play aborts, done stays clear
// R23 - condition change restarts stability timer
`timescale 1ns/1ps
`default_nettype none
`include "alfd_defs.svh"

module alfd_load_diag #(
    parameter int AW = 16,
    parameter int LP_SHIFT = `ALFD_LP_SHIFT,
    parameter int SHORT_STABLE_CYC = `ALFD_SHORT_STABLE_MS * `ALFD_CLK_KHZ,
    parameter int OLP_SETTLE_CYC = `ALFD_OLP_SETTLE_MS * `ALFD_CLK_KHZ,
    parameter int OLP_WINDOW_CYC = `ALFD_OLP_WINDOW_MS * `ALFD_CLK_KHZ,
    parameter int OLP_QUAL_CYC = `ALFD_OLP_QUAL_MS * `ALFD_CLK_KHZ
) (
    input wire logic clock, // core clock
    input wire logic reset_n, // async reset, low active
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_we_i, // bus write
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // bus acknowledge
    input wire logic chInMute, // channel in mute
    input wire logic chInPlay, // channel in play
    input wire logic chInIdle, // channel in low-power idle
    input wire logic powerStageOn, // power stage running
    input wire logic hardwareSilencePin_n, // silence pin, low mutes
    input wire logic shortCircuitTrip, // protection trip pulse
    input wire logic shortToSupplyRaw, // comparator level
    input wire logic shortToGroundRaw, // comparator level
    input wire logic loadTestDone, // front end finished pulse
    input wire logic loadTestOpen, // open load seen
    input wire logic loadTestShort, // short load seen
    input wire logic startAnalogMute, // mute ramp start pulse
    input wire logic [AW-1:0] audioSample, // signed input sample
    input wire logic audioValid, // sample strobe
    input wire logic impedanceAbove, // impedance above threshold
    output logic dcTestRun, // drive test signal
    output logic [1:0] loadThrSel, // short, open limits
    output logic [1:0] olpThrSel, // gain, open threshold
    output logic olpActive, // detector circuits on
    output logic protectActive, // protected status
    output logic powerStageReq, // power stage request
    output logic playReq, // play request
    output logic faultPinOut, // fault pin level
    output logic faultPinOe_n // fault pin enable, low drives
);
    // ----------------------------------------
    // parameter checks
    // ----------------------------------------
    localparam int CW = $clog2(OLP_WINDOW_CYC + 1);
    localparam int SW = $clog2(SHORT_STABLE_CYC + 1);
    localparam int TH25 = (`ALFD_AMP_TH25_MFS * (1 << (AW - 1))) / 1000;
    localparam int TH15 = (`ALFD_AMP_TH15_MFS * (1 << (AW - 1))) / 1000;

    generate
        if (AW < 8 || AW > 24 || LP_SHIFT < 1 || LP_SHIFT >= AW || SHORT_STABLE_CYC < 2 ||
            OLP_SETTLE_CYC < 2 || OLP_QUAL_CYC < 2 || OLP_WINDOW_CYC <= OLP_QUAL_CYC ||
            OLP_SETTLE_CYC > OLP_WINDOW_CYC) begin : g_badParams
            $error("alfd_load_diag: parameter values not supported");
        end
    endgenerate

    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [2:0] syncA_ff;
    logic [2:0] syncB_ff;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            syncA_ff <= 3'h7;
            syncB_ff <= 3'h7;
        end else begin
            syncA_ff <= {hardwareSilencePin_n, shortToSupplyRaw, shortToGroundRaw};
            syncB_ff <= syncA_ff;
        end
    end
    wire hwSilence = !syncB_ff[2];
    wire [1:0] shortCond = syncB_ff[1:0];

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic olpStart_ff;
    logic gain_ff;
    logic [1:0] thr_ff;
    logic ltStart_ff;
    logic [`ALFD_ROUTE_W-1:0] route_ff;
    logic [1:0] cmd_ff;
    logic [3:0] ltRes_ff;
    logic [2:0] play_ff;
    logic sam_ff;

    wire req = wb_cyc_i && wb_stb_i;
    wire wrEn = req && wb_we_i && ack_ff && wb_sel_i[0];
    wire rdDone = req && !wb_we_i && ack_ff;
    wire wrDetStart = wrEn && (wb_adr_i == `ALFD_ADR_DETECTOR_START);
    wire wrGain = wrEn && (wb_adr_i == `ALFD_ADR_GAIN_RAMP);
    wire wrThr = wrEn && (wb_adr_i == `ALFD_ADR_LOAD_THR);
    wire wrLtCtrl = wrEn && (wb_adr_i == `ALFD_ADR_LOAD_TEST_CTRL);
    wire wrRoute = wrEn && (wb_adr_i == `ALFD_ADR_FAULT_ROUTE);
    wire wrCmd = wrEn && (wb_adr_i == `ALFD_ADR_MODE_CMD);
    wire rdRes = rdDone && (wb_adr_i == `ALFD_ADR_LOAD_RESULT);
    wire rdPlay = rdDone && (wb_adr_i == `ALFD_ADR_PLAY_STATUS);
    wire rdMute = rdDone && (wb_adr_i == `ALFD_ADR_MUTE_STATUS);

    wire [31:0] rdMux =
        (wb_adr_i == `ALFD_ADR_DETECTOR_START) ? {31'h0, olpStart_ff} :
        (wb_adr_i == `ALFD_ADR_GAIN_RAMP) ? {27'h0, gain_ff, 4'h0} :
        (wb_adr_i == `ALFD_ADR_LOAD_THR) ? {24'h0, thr_ff, 6'h0} :
        (wb_adr_i == `ALFD_ADR_LOAD_TEST_CTRL) ? {31'h0, ltStart_ff} :
        (wb_adr_i == `ALFD_ADR_FAULT_ROUTE) ? {27'h0, route_ff} :
        (wb_adr_i == `ALFD_ADR_MODE_CMD) ? {30'h0, cmd_ff} :
        (wb_adr_i == `ALFD_ADR_LOAD_RESULT) ? {28'h0, ltRes_ff} :
        (wb_adr_i == `ALFD_ADR_PLAY_STATUS) ? {29'h0, play_ff} :
        (wb_adr_i == `ALFD_ADR_MUTE_STATUS) ? {27'h0, sam_ff, 4'h0} : 32'h0;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0;
        end else begin
            ack_ff <= req && !ack_ff;
            rdat_ff <= rdMux;
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            gain_ff <= 1'b0;
            thr_ff <= 2'h0;
            route_ff <= `ALFD_RST_ROUTE;
            cmd_ff <= 2'h0;
        end else begin
            if (wrGain) gain_ff <= wb_dat_i[`ALFD_GAIN_BIT];
            if (wrThr) thr_ff <= {wb_dat_i[`ALFD_THR_SHORT_BIT], wb_dat_i[`ALFD_THR_OPEN_BIT]};
            if (wrRoute) route_ff <= wb_dat_i[`ALFD_ROUTE_W-1:0];
            if (wrCmd) cmd_ff <= {wb_dat_i[`ALFD_CMD_PLAY_BIT], wb_dat_i[`ALFD_CMD_PWR_BIT]};
        end
    end
    assign loadThrSel = thr_ff; // R11
    assign olpThrSel = {gain_ff, thr_ff[0]}; // R20

    // ----------------------------------------
    // protection and short diagnosis
    // ----------------------------------------
    alfd_pkg::alfd_prot_t prot_ff;
    alfd_pkg::alfd_prot_t nxt_prot;
    logic [1:0] condPrev_ff;
    logic [SW-1:0] sdCnt_ff;
    logic dcRun_ff;
    logic dcArm_ff;

    wire condChanged = (shortCond != condPrev_ff);
    wire stableDone = !condChanged && (sdCnt_ff == SW'(SHORT_STABLE_CYC - 1)); // R12
    wire inShortDiag = (prot_ff == alfd_pkg::PR_SHORT_DIAG);
    wire dcEnd = dcRun_ff && loadTestDone;
    wire [SW-1:0] nxt_sdCnt = (!inShortDiag || condChanged) ? SW'(0) : // R23
        (stableDone ? sdCnt_ff : sdCnt_ff + SW'(1));

    always_comb begin
        nxt_prot = prot_ff;
        case (prot_ff)
            alfd_pkg::PR_IDLE: begin
                if (shortCircuitTrip) nxt_prot = alfd_pkg::PR_SHORT_DIAG; // R9
            end
            alfd_pkg::PR_SHORT_DIAG: begin
                if (stableDone && shortCond == 2'b00) begin // R14
                    nxt_prot = ltStart_ff ? alfd_pkg::PR_LOAD_TEST : alfd_pkg::PR_IDLE; // R10
                end
            end
            alfd_pkg::PR_LOAD_TEST: begin
                if (dcEnd) nxt_prot = alfd_pkg::PR_IDLE;
            end
            default: nxt_prot = alfd_pkg::PR_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prot_ff <= alfd_pkg::PR_IDLE;
            condPrev_ff <= 2'h0;
            sdCnt_ff <= SW'(0);
        end else begin
            prot_ff <= nxt_prot;
            condPrev_ff <= shortCond;
            sdCnt_ff <= nxt_sdCnt;
        end
    end
    assign protectActive = (prot_ff != alfd_pkg::PR_IDLE);

    // ----------------------------------------
    // DC load test
    // ----------------------------------------
    wire ltRise = wrLtCtrl && wb_dat_i[`ALFD_LT_START_BIT] && !ltStart_ff; // R4
    wire muteReady = chInMute && powerStageOn && !hwSilence && (prot_ff == alfd_pkg::PR_IDLE); // R4
    wire dcGo = !dcRun_ff && ((dcArm_ff && muteReady) || (prot_ff == alfd_pkg::PR_LOAD_TEST)); // R6 R10
    wire nxt_ltStart = dcEnd ? 1'b0 : (wrLtCtrl ? wb_dat_i[`ALFD_LT_START_BIT] : ltStart_ff); // R5
    wire nxt_dcArm = (dcEnd || dcGo || (wrLtCtrl && !wb_dat_i[`ALFD_LT_START_BIT])) ? 1'b0 :
        (ltRise ? 1'b1 : dcArm_ff);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ltStart_ff <= 1'b0;
            dcArm_ff <= 1'b0;
            dcRun_ff <= 1'b0;
        end else begin
            ltStart_ff <= nxt_ltStart;
            dcArm_ff <= nxt_dcArm;
            dcRun_ff <= dcGo || (dcRun_ff && !loadTestDone);
        end
    end
    assign dcTestRun = dcRun_ff;
    // power at once, play held back while a test is pending or running or protection is active
    assign powerStageReq = cmd_ff[0]; // R7
    assign playReq = cmd_ff[1] && !dcArm_ff && !dcRun_ff && !protectActive; // R7

    // ----------------------------------------
    // warning latches, set wins over read clear
    // ----------------------------------------
    wire [3:0] resSet = {stableDone && shortCond[1], stableDone && shortCond[0], // R13
        dcEnd && loadTestOpen, dcEnd && loadTestShort}; // R5
    wire [2:0] playSet;
    wire [3:0] nxt_ltRes = resSet | (rdRes ? 4'h0 : ltRes_ff); // R1
    wire [2:0] nxt_play = playSet | (rdPlay ? 3'h0 : play_ff); // R1
    wire nxt_sam = startAnalogMute || (sam_ff && !rdMute); // R1

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ltRes_ff <= `ALFD_RST_RESULT;
            play_ff <= `ALFD_RST_PLAY;
            sam_ff <= 1'b0;
        end else begin
            ltRes_ff <= nxt_ltRes;
            play_ff <= nxt_play;
            sam_ff <= nxt_sam;
        end
    end

    // ----------------------------------------
    // fault pin
    // ----------------------------------------
    wire [`ALFD_ROUTE_W-1:0] faultSrc = {play_ff[2] && play_ff[1] && play_ff[0], ltRes_ff};
    assign faultPinOut = 1'b0;
    assign faultPinOe_n = !(|(faultSrc & route_ff)); // R2

    // ----------------------------------------
    // open load in play
    // ----------------------------------------
    alfd_pkg::alfd_olp_t olp_ff;
    alfd_pkg::alfd_olp_t nxt_olp;
    logic [CW-1:0] olCnt_ff;
    logic [CW-1:0] qualCnt_ff;
    logic [CW-1:0] aboveCnt_ff;
    logic [AW-1:0] env_ff;

    wire [AW-1:0] ampAbs = audioSample[AW-1] ? AW'(-audioSample) : audioSample;
    wire signed [AW:0] envDiff = $signed({1'b0, ampAbs}) - $signed({1'b0, env_ff});
    wire signed [AW:0] envStep = envDiff >>> LP_SHIFT;
    wire signed [AW:0] envSum = $signed({1'b0, env_ff}) + envStep;
    wire [AW-1:0] nxt_env = audioValid ? envSum[AW-1:0] : env_ff; // R17
    wire [AW-1:0] ampTh = thr_ff[0] ? AW'(TH15) : AW'(TH25); // R18
    wire qualified = (env_ff > ampTh); // R18
    wire olpRun = (olp_ff != alfd_pkg::OL_IDLE);
    wire olpAbort = olpRun && !chInPlay; // R22
    wire inEval = (olp_ff == alfd_pkg::OL_EVAL);
    wire qualDone = inEval && qualified && (qualCnt_ff == CW'(OLP_QUAL_CYC - 1)); // R19
    wire winDone = inEval && (olCnt_ff == CW'(OLP_WINDOW_CYC - 1)); // R19
    wire olpEnd = !olpAbort && (qualDone || winDone);
    wire settleDone = (olp_ff == alfd_pkg::OL_SETTLE) && (olCnt_ff == CW'(OLP_SETTLE_CYC - 1)); // R21
    wire [CW:0] above2 = {aboveCnt_ff, 1'b0};
    wire olOpen = qualDone && (above2 > {1'b0, qualCnt_ff}); // R16
    assign playSet = {olpEnd, qualDone && !olpAbort, olOpen && !olpAbort}; // R15 R21

    always_comb begin
        nxt_olp = olp_ff;
        case (olp_ff)
            alfd_pkg::OL_IDLE: begin
                if (olpStart_ff && chInPlay) nxt_olp = alfd_pkg::OL_SETTLE; // R21
            end
            alfd_pkg::OL_SETTLE: begin
                if (olpAbort) nxt_olp = alfd_pkg::OL_IDLE;
                else if (settleDone) nxt_olp = alfd_pkg::OL_EVAL;
            end
            alfd_pkg::OL_EVAL: begin
                if (olpAbort || olpEnd) nxt_olp = alfd_pkg::OL_IDLE;
            end
            default: nxt_olp = alfd_pkg::OL_IDLE;
        endcase
    end

    wire nxt_olpStart = (olpEnd || olpAbort) ? 1'b0 : // R21 R22
        (wrDetStart ? wb_dat_i[`ALFD_OLP_START_BIT] : olpStart_ff);
    wire [CW-1:0] nxt_olCnt = (nxt_olp != olp_ff) ? CW'(0) : olCnt_ff + CW'(olpRun);
    wire countQual = inEval && qualified;
    wire [CW-1:0] nxt_qualCnt = inEval ? qualCnt_ff + CW'(countQual) : CW'(0);
    wire [CW-1:0] nxt_aboveCnt = inEval ? aboveCnt_ff + CW'(countQual && impedanceAbove) : CW'(0); // R16

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            olp_ff <= alfd_pkg::OL_IDLE;
            olpStart_ff <= 1'b0;
            olCnt_ff <= CW'(0);
            qualCnt_ff <= CW'(0);
            aboveCnt_ff <= CW'(0);
            env_ff <= AW'(0);
        end else begin
            olp_ff <= nxt_olp;
            olpStart_ff <= nxt_olpStart;
            olCnt_ff <= nxt_olCnt;
            qualCnt_ff <= nxt_qualCnt;
            aboveCnt_ff <= nxt_aboveCnt;
            env_ff <= nxt_env;
        end
    end
    assign olpActive = olpRun;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cbAst @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence sLoadEnd;
        dcRun_ff && loadTestDone;
    endsequence
    sequence sResultRead;
        rdRes && (resSet == 4'h0);
    endsequence

    AST_READ_CLEARS: assert property (sResultRead |=> ltRes_ff == 4'h0) // R1
        else $error("load result not cleared by read");
    AST_FAULT_PIN: assert property (ltRes_ff[3] && route_ff[3] |-> !faultPinOe_n && !faultPinOut) // R2
        else $error("routed fault did not pull pin");
    AST_START_COND: assert property ($rose(dcRun_ff) && $past(prot_ff) == alfd_pkg::PR_IDLE
        |-> $past(chInMute && powerStageOn && !hwSilence && dcArm_ff)) // R4
        else $error("load test started outside its conditions");
    AST_END_CLEARS: assert property (sLoadEnd |=> !ltStart_ff && !dcRun_ff) // R5
        else $error("start bit not cleared at test end");
    AST_PLAY_HELD: assert property (dcArm_ff || dcRun_ff |-> !playReq) // R7
        else $error("play requested before load test done");
    AST_TRIP_PROTECT: assert property (prot_ff == alfd_pkg::PR_IDLE && shortCircuitTrip
        |=> protectActive && sdCnt_ff == SW'(0)) // R9
        else $error("trip did not enter short diagnosis");
    AST_TIMER_RESTART: assert property (inShortDiag && condChanged |=> sdCnt_ff == SW'(0)) // R23
        else $error("stability timer not restarted");
    AST_SHORT_FLAG: assert property (inShortDiag && stableDone && shortCond[1]
        |=> ltRes_ff[3] && inShortDiag) // R13
        else $error("stable short not flagged");
    AST_OLP_ABORT: assert property (olpAbort |=> olp_ff == alfd_pkg::OL_IDLE && !olpStart_ff
        && !$rose(play_ff[2])) // R22
        else $error("leaving play did not abort cleanly");
    AST_ACK_ONE: assert property (req && !ack_ff |=> ack_ff ##1 !ack_ff)
        else $error("bus ack not single cycle");
endmodule : alfd_load_diag
`default_nettype wire

// ==== tb/alfd_host_model.sv ====
/*
  Wishbone master standing in for the serial host controller that configures and polls the block.
  Assumes the bench calls xfer and that every request is answered by an ack.
*/
`timescale 1ns/1ps
`default_nettype none
module alfd_host_model (
    input wire logic clock, // core clock
    input wire logic ack, // bus acknowledge
    input wire logic [31:0] datIn, // read data
    output logic cyc, // bus cycle
    output logic stb, // bus strobe
    output logic we, // bus write
    output logic [7:0] adr, // byte address
    output logic [3:0] sel, // byte lanes
    output logic [31:0] datOut // write data
);
    initial begin
        {cyc, stb, we, adr, sel, datOut} = '0;
    end
    // ----------------------------------------
    // one classic cycle; the host writes configuration and start bits and reads status
    // ----------------------------------------
    // modulation select is never touched, so it stays in phase during a
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        datOut <= d;
        do @(posedge clock); while (ack !== 1'b1);
        q = datIn;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer
endmodule : alfd_host_model
`default_nettype wire

// ==== tb/test_amp_load_fault_diagnostics.sv ====
/*
  Self-checking bench of the load fault diagnostics block with shortened counts.
  Assumes alfd_load_diag, alfd_host_model and a 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module test_amp_load_fault_diagnostics;
    logic clock, reset_n, cyc, stb, we, ack, mute, play, pwr, silenceN, trip, supRaw, gndRaw;
    logic ltDone, ltOpen, ltShort, sam, impAbove, hiAmp, dcTestRun, protectActive, powerStageReq;
    logic playReq, faultPinOe_n, o, olpAct, pinLvl;
    logic [1:0] loadThrSel, olpThrSel, t;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [15:0] sample;
    logic [31:0] wdat, rdat, q;
    int mismatches = 0;
    int n_compared = 0;

    alfd_host_model host (.clock(clock), .ack(ack), .datIn(rdat), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .sel(sel), .datOut(wdat));
    alfd_load_diag #(.SHORT_STABLE_CYC(20), .OLP_SETTLE_CYC(10), .OLP_QUAL_CYC(30), .OLP_WINDOW_CYC(100)) DUT (
        .clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .chInMute(mute), .chInPlay(play),
        .chInIdle(!play), .powerStageOn(pwr), .hardwareSilencePin_n(silenceN), .shortCircuitTrip(trip),
        .shortToSupplyRaw(supRaw), .shortToGroundRaw(gndRaw), .loadTestDone(ltDone), .loadTestOpen(ltOpen),
        .loadTestShort(ltShort), .startAnalogMute(sam), .audioSample(sample), .audioValid(1'b1),
        .impedanceAbove(impAbove), .dcTestRun(dcTestRun), .loadThrSel(loadThrSel), .olpThrSel(olpThrSel),
        .olpActive(olpAct), .protectActive(protectActive), .powerStageReq(powerStageReq), .playReq(playReq),
        .faultPinOut(pinLvl), .faultPinOe_n(faultPinOe_n));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        sample <= hiAmp ? 16'h2000 + 16'($urandom % 4096) : 16'($urandom % 400);
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] ply_exp(input logic hi, input logic imp);
        return {29'h0, 1'b1, hi, hi & imp};
    endfunction : ply_exp
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task end_sim;
        if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    task wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, q);
        check(q, e);
    endtask : rdc
    task cycles(input int n);
        repeat (n) @(posedge clock);
    endtask : cycles
    task wait_run(input int n);
        for (int i = 0; i < n && dcTestRun !== 1'b1; i++) @(posedge clock);
    endtask : wait_run
    task finish_dc(input logic op);
        @(posedge clock);
        ltDone <= 1'b1;
        ltOpen <= op;
        ltShort <= !op;
        @(posedge clock);
        ltDone <= 1'b0;
        @(posedge clock);
    endtask : finish_dc
    initial begin
        #2000000;
        mismatches++;
        end_sim();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h117B78A2));
        {reset_n, mute, play, pwr, trip, supRaw, gndRaw, ltDone, ltOpen, ltShort, sam, impAbove, hiAmp} = '0;
        silenceN = 1'b1;
        cycles(20);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) rdc(8'h18 + 8'(4 * i), 32'h0);
        @(posedge clock) sam <= 1'b1;
        @(posedge clock) sam <= 1'b0;
        rdc(8'h20, 32'h10);
        rdc(8'h20, 32'h0);
        t = 2'($urandom);
        o = 1'($urandom);
        wr(8'h08, {24'h0, t, 6'h0});
        wr(8'h04, {27'h0, o, 4'h0});
        cycles(1);
        check(loadThrSel, t);
        check(olpThrSel, {o, t[0]});
        @(posedge clock) pwr <= 1'b1;
        wr(8'h10, 32'hA);
        wr(8'h14, 32'h3);
        wr(8'h0C, 32'h1);
        cycles(5);
        check(dcTestRun, 32'h0);
        check(playReq, 32'h0);
        check(powerStageReq, 32'h1);
        // the pin passes two flip-flops, so it must be low before mute is entered
        @(posedge clock) silenceN <= 1'b0;
        cycles(3);
        mute <= 1'b1;
        cycles(6);
        check(dcTestRun, 32'h0);
        @(posedge clock) silenceN <= 1'b1;
        wait_run(20);
        check(dcTestRun, 32'h1);
        finish_dc(o);
        check(dcTestRun, 32'h0);
        check(playReq, 32'h1);
        check(faultPinOe_n, {31'h0, !o});
        check(pinLvl, 32'h0);
        rdc(8'h0C, 32'h0);
        rdc(8'h18, o ? 32'h2 : 32'h1);
        cycles(1);
        check(faultPinOe_n, 32'h1);
        @(posedge clock) mute <= 1'b0;
        wr(8'h14, 32'h0);
        wr(8'h0C, 32'h1);
        @(posedge clock) trip <= 1'b1;
        @(posedge clock) trip <= 1'b0;
        wait_run(80);
        check(dcTestRun, 32'h1);
        check(protectActive, 32'h1);
        finish_dc(1'b0);
        cycles(2);
        check(protectActive, 32'h0);
        rdc(8'h0C, 32'h0);
        rdc(8'h18, 32'h1);
        for (int k = 0; k < 2; k++) begin
            @(posedge clock) trip <= 1'b1;
            @(posedge clock) trip <= 1'b0;
            for (int j = 0; j < 5; j++) begin
                @(posedge clock) supRaw <= !j[0] && k == 0;
                gndRaw <= !j[0] && k == 1;
                cycles(j == 4 ? 30 : 3 + $urandom % 8);
                if (j == 3) rdc(8'h18, 32'h0);
            end
            check(protectActive, 32'h1);
            check(faultPinOe_n, 32'(k));
            @(posedge clock) {supRaw, gndRaw} <= 2'h0;
            cycles(30);
            check(protectActive, 32'h0);
            rdc(8'h18, 32'h8 >> k);
        end
        @(posedge clock) play <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            @(posedge clock) hiAmp <= k < 2;
            impAbove <= k == 0;
            wr(8'h00, 32'h1);
            q = 32'h1;
            for (int i = 0; i < 60 && q[0] !== 1'b0; i++) host.xfer(1'b0, 8'h00, 32'h0, q);
            check(q, 32'h0);
            rdc(8'h1C, ply_exp(k < 2, k == 0));
        end
        rdc(8'h1C, 32'h0);
        wr(8'h00, 32'h1);
        cycles(5);
        check(olpAct, 32'h1);
        @(posedge clock) play <= 1'b0;
        cycles(3);
        check(olpAct, 32'h0);
        rdc(8'h00, 32'h0);
        rdc(8'h1C, 32'h0);
        end_sim();
    end
endmodule : test_amp_load_fault_diagnostics
`default_nettype wire
